// [src/pcm_pkg.sv]
package pcm_pkg;

    // register indices; byte address is index times four
    localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
    localparam logic [9:0] IDX_EXTENDED_FLAGS = 10'h091;
    localparam logic [9:0] IDX_CLOCK_DIVIDE = 10'h0C4;
    localparam logic [9:0] IDX_WATCHDOG_POWER = 10'h0D8;
    localparam logic [9:0] IDX_EXT_IRQ_ENABLE = 10'h0E8;

    // power_control fields
    localparam int PC_STOP = 1;
    localparam int PC_IDLE = 0;
    // extended_flags fields
    localparam int EF_RING_MODE = 2;
    localparam int EF_RING_SEL = 1;
    localparam int EF_REF_STOP = 0;
    // clock_divide_control fields
    localparam int CD_HI = 7;
    localparam int CD_LO = 6;
    localparam int CD_SWB = 5;
    localparam int CD_MUL_EN = 4;
    localparam int CD_RATIO = 3;
    localparam int CD_CLOCK_READY = 0;
    // watchdog_power_control fields
    localparam int WP_POR = 6;
    localparam int WP_PF_EN = 5;
    localparam int WP_PF_FLAG = 4;
    localparam int WP_WD_FLAG = 3;
    localparam int WP_WD_RFLAG = 2;
    localparam int WP_WD_REN = 1;
    localparam int WP_RESTART = 0;
    // extended_interrupt_enable fields
    localparam int IE_WD_EN = 4;

    // divide field encodings
    localparam logic [1:0] CD_MULT = 2'h0;
    localparam logic [1:0] CD_RSVD = 2'h1;
    localparam logic [1:0] CD_DIV1 = 2'h2;
    localparam logic [1:0] CD_DIV1024 = 2'h3;

    localparam logic [1:0] RESET_CD = CD_DIV1;
    localparam logic RESET_POR = 1'h1;
    localparam logic [7:0] RESET_EIE = 8'h00;

    localparam int WDT_GRACE_CYCLES = 512;
    localparam int CNT_W = 18;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        SEL_PWR, SEL_EXF, SEL_DIV, SEL_WDP, SEL_EIE, SEL_NONE
    } pcm_sel_type;

    typedef enum {ST_RUN, ST_STOP, ST_RING, ST_XWAIT} pcm_state_type;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } pcm_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pcm_axi_rsp_type;

endpackage

// [src/pcm_countdown.sv]
`timescale 1ns/10ps
module pcm_countdown (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic abort,
    input wire logic [pcm_pkg::CNT_W-1:0] count,
    output logic busy,
    output logic done
);
    logic [pcm_pkg::CNT_W-1:0] cnt_reg;

    // done pulses count+1 edges after the load edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (load) begin
                cnt_reg <= count;
                busy <= 1'b1;
            end else if (busy) begin
                if (cnt_reg == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end
endmodule // pcm_countdown

// [src/pcm_power_clock.sv]
`timescale 1ns/10ps
// Behaviour
// - power-up reset sets power-on flag; only a software write clears it
// - power-fail interrupt raised only while its enable bit is one
// - power-fail sets sticky flag; writing one forces the interrupt if enabled
// - watchdog time-out sets flag; reset follows 512 clocks later unless strobed
// - watchdog reset sets reset flag; power-fail reset clears it
// - reset enable gates only the reset; interrupt needs its own enable
// - software strobes restart bit each period; bit clears itself
// - reference select zero: no power-fail interrupt or reset in stop
// - stop halts execution and all clocks; idle halts only execution
// - ring-mode status shows one while running from ring oscillator
// - ring select: stop exit runs from ring, crystal after 65,536 cycles
// - no ring select: stop exit holds execution until crystal count ends
// - ring select cleared only by power-on reset
// - divide code 01b acts as 10b, divide-by-1, for timer and multiplier logic; divideMode shows 01b
// - every reset returns divider to divide-by-1
// - divide-by-1024 with switchback: enabled external interrupt forces divide-by-1
// - serial start bit also switches back; only from divide-by-1024
// - ratios 0.25, 0.5 and 1 feed timers through fixed divide-by-12
// - multiplier ratio writes ignored unless multiplier enable is zero
// - multiplier enable changes only in divide-by-1 with ring status zero
// - enabling multiplier clears clock-ready, starts count; 00b refused meanwhile
// - every reset clears multiplier enable
module pcm_power_clock #(
    parameter int WDT_TIMEOUT_CYCLES = 131072,
    parameter int XTAL_START_CYCLES = 65536,
    parameter int MUL_START_CYCLES = 8192
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire pcm_pkg::pcm_axi_req_type busReq,
    output pcm_pkg::pcm_axi_rsp_type busRsp,
    input wire logic powerFailDet,
    input wire logic powerFailRstReq,
    input wire logic extRstReq,
    input wire logic extIrqDet,
    input wire logic serialStartDet,
    input wire logic anyIrqWake,
    output logic powerFailIrq,
    output logic watchdogIrq,
    output logic watchdogRst,
    output logic stopMode,
    output logic idleMode,
    output logic ringClock,
    output logic cpuHold,
    output logic refActive,
    output logic [1:0] divideMode,
    output logic multRatio4x,
    output logic timerDiv12
);
    function automatic pcm_pkg::pcm_sel_type regSel(input logic [11:0] a);
        if (a[1:0] != 2'h0) return pcm_pkg::SEL_NONE;
        case (a[11:2])
            pcm_pkg::IDX_POWER_CONTROL: return pcm_pkg::SEL_PWR;
            pcm_pkg::IDX_EXTENDED_FLAGS: return pcm_pkg::SEL_EXF;
            pcm_pkg::IDX_CLOCK_DIVIDE: return pcm_pkg::SEL_DIV;
            pcm_pkg::IDX_WATCHDOG_POWER: return pcm_pkg::SEL_WDP;
            pcm_pkg::IDX_EXT_IRQ_ENABLE: return pcm_pkg::SEL_EIE;
            default: return pcm_pkg::SEL_NONE;
        endcase
    endfunction

    // bus state
    logic awRdy_reg, wRdy_reg, awHave_reg, wHave_reg;
    logic bValid_reg, arRdy_reg, rValid_reg;
    logic [1:0] bResp_reg, rResp_reg;
    logic [11:0] awAddr_reg;
    logic [31:0] wData_reg, rData_reg;
    logic [3:0] wStrb_reg;
    // control and status state
    logic stop_reg, idle_reg, ringSel_reg, refStop_reg, ringMode_reg;
    logic hold_reg;
    logic [1:0] cd_reg;
    logic swb_reg, mulEn_reg, ratio_reg, clock_ready_reg;
    logic por_reg, pfEn_reg, pfFlag_reg, wdFlag_reg, wdRFlag_reg;
    logic wdREn_reg, rwt_reg;
    logic [7:0] eie_reg;
    logic pfIrq_reg, wdIrq_reg, wdRst_reg, refOn_reg, div12_reg;
    logic [pcm_pkg::CNT_W-1:0] wdCnt_reg;
    pcm_pkg::pcm_state_type state_reg;

    logic doWrite, wrOk, softRst, pfRst, pfCond, wdTimeout, stopped;
    logic xtalDone, mulDone, graceDone, mulLoad, xtalLoad;
    logic mulAllowed, switchBack;
    logic [7:0] wd;
    logic [1:0] cdEff;
    pcm_pkg::pcm_sel_type wSel, rSel;

    assign doWrite = awHave_reg && wHave_reg && !bValid_reg;
    assign wSel = regSel(awAddr_reg);
    assign rSel = regSel(busReq.araddr);
    assign wrOk = doWrite && wStrb_reg[0] && (wSel != pcm_pkg::SEL_NONE);
    assign wd = wData_reg[7:0];
    assign stopped = (state_reg == pcm_pkg::ST_STOP);
    // monitor is off in stop unless software keeps the reference on
    assign pfCond = powerFailDet && (!stopped || refStop_reg);
    assign pfRst = powerFailRstReq && (!stopped || refStop_reg);
    assign softRst = extRstReq || pfRst || wdRst_reg;
    assign cdEff = (cd_reg == pcm_pkg::CD_RSVD) ? pcm_pkg::CD_DIV1 : cd_reg;
    assign mulAllowed = (cdEff == pcm_pkg::CD_DIV1) && !ringMode_reg;
    assign mulLoad = wrOk && (wSel == pcm_pkg::SEL_DIV) && mulAllowed && wd[pcm_pkg::CD_MUL_EN] && !mulEn_reg;
    assign switchBack = (cd_reg == pcm_pkg::CD_DIV1024) && swb_reg && (extIrqDet || serialStartDet);
    assign wdTimeout = !stopped && !rwt_reg && (wdCnt_reg == pcm_pkg::CNT_W'(WDT_TIMEOUT_CYCLES - 1));
    assign xtalLoad = stopped && !softRst && (extIrqDet || (pfCond && pfEn_reg));

    // AXI4-Lite write channel
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awRdy_reg <= 1'b1;
            wRdy_reg <= 1'b1;
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            bValid_reg <= 1'b0;
            bResp_reg <= pcm_pkg::RESP_OKAY;
            awAddr_reg <= '0;
            wData_reg <= '0;
            wStrb_reg <= '0;
        end else begin
            if (busReq.awvalid && awRdy_reg) begin
                awAddr_reg <= busReq.awaddr;
                awHave_reg <= 1'b1;
                awRdy_reg <= 1'b0;
            end
            if (busReq.wvalid && wRdy_reg) begin
                wData_reg <= busReq.wdata;
                wStrb_reg <= busReq.wstrb;
                wHave_reg <= 1'b1;
                wRdy_reg <= 1'b0;
            end
            if (doWrite) begin
                bValid_reg <= 1'b1;
                bResp_reg <= (wSel == pcm_pkg::SEL_NONE) ? pcm_pkg::RESP_DECERR : pcm_pkg::RESP_OKAY;
                awHave_reg <= 1'b0;
                wHave_reg <= 1'b0;
            end
            if (bValid_reg && busReq.bready) begin
                bValid_reg <= 1'b0;
                awRdy_reg <= 1'b1;
                wRdy_reg <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            arRdy_reg <= 1'b1;
            rValid_reg <= 1'b0;
            rData_reg <= '0;
            rResp_reg <= pcm_pkg::RESP_OKAY;
        end else if (busReq.arvalid && arRdy_reg) begin
            arRdy_reg <= 1'b0;
            rValid_reg <= 1'b1;
            rResp_reg <= pcm_pkg::RESP_OKAY;
            rData_reg <= '0;
            case (rSel)
                pcm_pkg::SEL_PWR: rData_reg[1:0] <= {stop_reg, idle_reg};
                pcm_pkg::SEL_EXF: rData_reg[2:0] <= {ringMode_reg, ringSel_reg, refStop_reg};
                pcm_pkg::SEL_DIV: rData_reg[7:0] <= {cd_reg, swb_reg, mulEn_reg, ratio_reg, 2'h0, clock_ready_reg};
                pcm_pkg::SEL_WDP: rData_reg[7:0] <= {1'b0, por_reg, pfEn_reg, pfFlag_reg, wdFlag_reg,
                                                     wdRFlag_reg, wdREn_reg, rwt_reg};
                pcm_pkg::SEL_EIE: rData_reg[7:0] <= eie_reg;
                default: rResp_reg <= pcm_pkg::RESP_DECERR;
            endcase
        end else if (rValid_reg && busReq.rready) begin
            rValid_reg <= 1'b0;
            arRdy_reg <= 1'b1;
        end
    end

    assign busRsp = '{awready: awRdy_reg, wready: wRdy_reg, bvalid: bValid_reg, bresp: bResp_reg,
                      arready: arRdy_reg, rvalid: rValid_reg, rdata: rData_reg, rresp: rResp_reg};

    // watchdog_power_control flags; hardware set wins over software clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            por_reg <= pcm_pkg::RESET_POR;
            pfEn_reg <= 1'b0;
            pfFlag_reg <= 1'b0;
            wdFlag_reg <= 1'b0;
            wdRFlag_reg <= 1'b0;
            wdREn_reg <= 1'b0;
            rwt_reg <= 1'b0;
            eie_reg <= pcm_pkg::RESET_EIE;
        end else begin
            rwt_reg <= 1'b0;
            if (wrOk && wSel == pcm_pkg::SEL_WDP) begin
                if (!wd[pcm_pkg::WP_POR]) por_reg <= 1'b0;
                pfEn_reg <= wd[pcm_pkg::WP_PF_EN];
                pfFlag_reg <= wd[pcm_pkg::WP_PF_FLAG];
                if (!wd[pcm_pkg::WP_WD_FLAG]) wdFlag_reg <= 1'b0;
                if (!wd[pcm_pkg::WP_WD_RFLAG]) wdRFlag_reg <= 1'b0;
                wdREn_reg <= wd[pcm_pkg::WP_WD_REN];
                rwt_reg <= wd[pcm_pkg::WP_RESTART];
            end
            if (wrOk && wSel == pcm_pkg::SEL_EIE) eie_reg <= wd;
            if (pfCond) pfFlag_reg <= 1'b1;
            if (wdTimeout) wdFlag_reg <= 1'b1;
            // the flop feeding watchdogRst only fires with the reset enabled
            if (wdRst_reg) wdRFlag_reg <= 1'b1;
            if (softRst) begin
                pfEn_reg <= 1'b0;
                wdFlag_reg <= 1'b0;
                wdREn_reg <= 1'b0;
                rwt_reg <= 1'b0;
                eie_reg <= pcm_pkg::RESET_EIE;
            end
            if (pfRst) wdRFlag_reg <= 1'b0;
        end
    end

    // watchdog time base keeps counting whatever the reset enable says
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdCnt_reg <= '0;
        end else if (softRst || rwt_reg) begin
            wdCnt_reg <= '0;
        end else if (!stopped) begin
            wdCnt_reg <= wdTimeout ? '0 : wdCnt_reg + 1'b1;
        end
    end

    pcm_countdown graceCount (
        .clk(clk),
        .arst_n(arst_n),
        .load(wdTimeout),
        .abort(softRst || rwt_reg),
        .count(pcm_pkg::CNT_W'(pcm_pkg::WDT_GRACE_CYCLES - 2)),
        .busy(),
        .done(graceDone)
    );

    pcm_countdown xtalCount (
        .clk(clk),
        .arst_n(arst_n),
        .load(xtalLoad),
        .abort(softRst || (ringMode_reg && wrOk && wSel == pcm_pkg::SEL_PWR && wd[pcm_pkg::PC_STOP])),
        .count(pcm_pkg::CNT_W'(XTAL_START_CYCLES - 2)),
        .busy(),
        .done(xtalDone)
    );

    pcm_countdown mulCount (
        .clk(clk),
        .arst_n(arst_n),
        .load(mulLoad),
        .abort(softRst),
        .count(pcm_pkg::CNT_W'(MUL_START_CYCLES - 2)),
        .busy(),
        .done(mulDone)
    );

    // interrupt, reset and status outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pfIrq_reg <= 1'b0;
            wdIrq_reg <= 1'b0;
            wdRst_reg <= 1'b0;
            refOn_reg <= 1'b1;
            div12_reg <= 1'b1;
        end else begin
            pfIrq_reg <= pfFlag_reg && pfEn_reg;
            wdIrq_reg <= wdFlag_reg && eie_reg[pcm_pkg::IE_WD_EN];
            wdRst_reg <= graceDone && wdREn_reg && !rwt_reg;
            refOn_reg <= !stopped || refStop_reg;
            div12_reg <= cdEff != pcm_pkg::CD_DIV1024;
        end
    end

    // power_control and extended_flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ringSel_reg <= 1'b0;
            refStop_reg <= 1'b0;
            idle_reg <= 1'b0;
        end else begin
            if (wrOk && wSel == pcm_pkg::SEL_EXF) begin
                ringSel_reg <= wd[pcm_pkg::EF_RING_SEL];
                refStop_reg <= wd[pcm_pkg::EF_REF_STOP];
            end
            // stop takes precedence when both are requested
            if (wrOk && wSel == pcm_pkg::SEL_PWR && !wd[pcm_pkg::PC_STOP]) begin
                idle_reg <= wd[pcm_pkg::PC_IDLE];
            end
            if (anyIrqWake) idle_reg <= 1'b0;
            if (softRst) begin
                refStop_reg <= 1'b0;
                idle_reg <= 1'b0;
            end
        end
    end

    // stop entry and wake-up clock sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= pcm_pkg::ST_RUN;
            stop_reg <= 1'b0;
            ringMode_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else if (softRst) begin
            state_reg <= pcm_pkg::ST_RUN;
            stop_reg <= 1'b0;
            ringMode_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            case (state_reg)
                pcm_pkg::ST_RUN, pcm_pkg::ST_RING: begin
                    if (wrOk && wSel == pcm_pkg::SEL_PWR && wd[pcm_pkg::PC_STOP]) begin
                        state_reg <= pcm_pkg::ST_STOP;
                        stop_reg <= 1'b1;
                        ringMode_reg <= 1'b0;
                    end else if (state_reg == pcm_pkg::ST_RING && xtalDone) begin
                        state_reg <= pcm_pkg::ST_RUN;
                        ringMode_reg <= 1'b0;
                    end
                end
                pcm_pkg::ST_STOP: begin
                    if (xtalLoad) begin
                        stop_reg <= 1'b0;
                        if (ringSel_reg) begin
                            state_reg <= pcm_pkg::ST_RING;
                            ringMode_reg <= 1'b1;
                        end else begin
                            state_reg <= pcm_pkg::ST_XWAIT;
                            hold_reg <= 1'b1;
                        end
                    end
                end
                pcm_pkg::ST_XWAIT: begin
                    if (xtalDone) begin
                        state_reg <= pcm_pkg::ST_RUN;
                        hold_reg <= 1'b0;
                    end
                end
                default: state_reg <= pcm_pkg::ST_RUN;
            endcase
        end
    end

    // clock_divide_control with its write interlocks
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cd_reg <= pcm_pkg::RESET_CD;
            swb_reg <= 1'b0;
            mulEn_reg <= 1'b0;
            ratio_reg <= 1'b0;
            clock_ready_reg <= 1'b0;
        end else if (softRst) begin
            cd_reg <= pcm_pkg::RESET_CD;
            swb_reg <= 1'b0;
            mulEn_reg <= 1'b0;
            clock_ready_reg <= 1'b0;
        end else begin
            if (wrOk && wSel == pcm_pkg::SEL_DIV) begin
                if (wd[pcm_pkg::CD_HI:pcm_pkg::CD_LO] != pcm_pkg::CD_MULT || clock_ready_reg) begin
                    cd_reg <= wd[pcm_pkg::CD_HI:pcm_pkg::CD_LO];
                end
                swb_reg <= wd[pcm_pkg::CD_SWB];
                if (mulAllowed) mulEn_reg <= wd[pcm_pkg::CD_MUL_EN];
                if (!mulEn_reg) ratio_reg <= wd[pcm_pkg::CD_RATIO];
            end
            if (mulLoad) clock_ready_reg <= 1'b0;
            else if (mulDone) clock_ready_reg <= 1'b1;
            if (switchBack) cd_reg <= pcm_pkg::CD_DIV1;
        end
    end

    assign powerFailIrq = pfIrq_reg;
    assign watchdogIrq = wdIrq_reg;
    assign watchdogRst = wdRst_reg;
    assign stopMode = stop_reg;
    assign idleMode = idle_reg;
    assign ringClock = ringMode_reg;
    assign cpuHold = hold_reg;
    assign refActive = refOn_reg;
    assign divideMode = cd_reg;
    assign multRatio4x = ratio_reg;
    assign timerDiv12 = div12_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_wd_expire;
        wdTimeout && wdREn_reg;
    endsequence
    sequence s_grace_end;
        graceDone && wdREn_reg && !rwt_reg && !softRst;
    endsequence

    a_por_sticky: assert property (por_reg && !(wrOk && wSel == pcm_pkg::SEL_WDP) |=> por_reg)
        else $error("power-on flag lost without a write");
    a_pf_irq_gate: assert property (!pfEn_reg |=> !powerFailIrq)
        else $error("power-fail interrupt while disabled");
    a_pf_flag_set: assert property (pfCond |=> pfFlag_reg ##1 (powerFailIrq || !$past(pfEn_reg)))
        else $error("power-fail flag or interrupt missing");
    a_wd_grace_len: assert property (s_wd_expire ##1 (!rwt_reg && !softRst && wdREn_reg)[*8]
        |-> !watchdogRst)
        else $error("watchdog reset came too early");
    a_wd_reset_cause: assert property (s_grace_end |=> watchdogRst ##1 wdRFlag_reg)
        else $error("watchdog reset or its flag missing");
    a_wd_ren_gate: assert property (!wdREn_reg |=> !watchdogRst)
        else $error("watchdog reset while reset disabled");
    a_restart_clear: assert property (rwt_reg |=> !rwt_reg && wdCnt_reg == '0)
        else $error("restart bit did not self-clear");
    a_ref_stop: assert property (stopped && !refStop_reg && !pfFlag_reg && !(wrOk && wSel == pcm_pkg::SEL_WDP)
        |-> !pfRst ##1 (!pfFlag_reg && !refActive))
        else $error("power monitor active in stop");
    a_ring_change: assert property (state_reg == pcm_pkg::ST_RING && xtalDone && !softRst
        && !(wrOk && wSel == pcm_pkg::SEL_PWR) |=> !ringClock)
        else $error("crystal changeover missed");
    a_ringsel_keep: assert property (softRst && !(wrOk && wSel == pcm_pkg::SEL_EXF)
        |=> $stable(ringSel_reg))
        else $error("ring select altered by reset");
    a_div_reset: assert property (softRst |=> divideMode == pcm_pkg::CD_DIV1 && !mulEn_reg)
        else $error("divider not restored by reset");
    a_switch_back: assert property (switchBack && !softRst |=> divideMode == pcm_pkg::CD_DIV1)
        else $error("switchback did not act");
    a_ratio_lock: assert property (mulEn_reg && !softRst |=> $stable(ratio_reg))
        else $error("ratio changed with multiplier on");
    a_clock_ready_start: assert property (mulLoad && !softRst |=> !clock_ready_reg && mulEn_reg)
        else $error("clock-ready not cleared at start");
endmodule // pcm_power_clock

// [verification/tb_power_clock_management.sv]
`timescale 1ns/10ps
module tb_power_clock_management;
    logic clk, arst_n, extRst, pfDet, extIrq, serStart, pfIrq, stopMode, ringClock, div12;
    logic wdIrq, wdRst, hold, refAct;
    logic [1:0] divMode, resp;
    logic [31:0] d;
    int errors, n_checks, i;
    pcm_pkg::pcm_axi_req_type req;
    pcm_pkg::pcm_axi_rsp_type rsp;
    pcm_power_clock #(.WDT_TIMEOUT_CYCLES(1024), .XTAL_START_CYCLES(64), .MUL_START_CYCLES(32)) dut (
        .clk(clk), .arst_n(arst_n), .busReq(req), .busRsp(rsp), .powerFailDet(pfDet), .powerFailRstReq(1'h0),
        .extRstReq(extRst), .extIrqDet(extIrq), .serialStartDet(serStart), .anyIrqWake(1'h0), .powerFailIrq(pfIrq),
        .watchdogIrq(wdIrq), .watchdogRst(wdRst), .stopMode(stopMode), .idleMode(), .ringClock(ringClock),
        .cpuHold(hold), .refActive(refAct), .divideMode(divMode), .multRatio4x(), .timerDiv12(div12));
    initial forever #2 clk = ~clk;
    task report_and_stop(input logic hung);
        errors += hung;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function logic exp_div12(input logic [1:0] c);
        return c != 2'h3;
    endfunction
    // one-cycle pulse on {extRst, pfDet, extIrq, serStart}, then let it settle
    task pulse(input logic [3:0] p);
        @(posedge clk) {extRst, pfDet, extIrq, serStart} <= p;
        @(posedge clk) {extRst, pfDet, extIrq, serStart} <= 4'h0;
        repeat (3) @(posedge clk);
    endtask
    // one write (w=1) or read (w=0); each channel released at its own handshake
    task xfer(input logic w, input logic [9:0] idx, input logic [7:0] val);
        int n;
        @(posedge clk);
        req <= '{w, {idx, 2'h0}, w, {24'h0, val}, 4'hF, w, !w, {idx, 2'h0}, !w};
        for (n = 0; n < 50 && !(rsp.bvalid || rsp.rvalid); n++) begin
            @(posedge clk);
            req.awvalid <= req.awvalid && !rsp.awready;
            req.wvalid <= req.wvalid && !rsp.wready;
            req.arvalid <= req.arvalid && !rsp.arready;
        end
        {req.bready, req.rready} <= 2'h0;
        {d, resp} = w ? {32'h0, rsp.bresp} : {rsp.rdata, rsp.rresp};
        if (n == 50) report_and_stop(1'h1);
    endtask
    initial begin
        i = $urandom(9);
        {clk, arst_n, extRst, pfDet, extIrq, serStart} = 6'h0;
        req = '0;
        repeat (12) @(posedge clk);
        arst_n <= 1'h1;
        xfer(1'h0, 10'h0D8, 8'h00);
        chk(d[6], 1'h1);
        xfer(1'h0, 10'h001, 8'h00);
        chk(resp, 2'h3);
        repeat (4) begin
            i = $urandom % 256;
            xfer(1'h1, 10'h0E8, i[7:0]);
            xfer(1'h0, 10'h0E8, 8'h00);
            chk(d, i);
        end
        for (i = 1; i < 4; i += 2) begin
            xfer(1'h1, 10'h0C4, {i[1:0], 6'h0});
            repeat (3) @(posedge clk);
            chk(div12, exp_div12(i[1:0]));
        end
        for (i = 0; i < 3; i++) begin
            xfer(1'h1, 10'h0C4, i ? 8'hE0 : 8'hC0);
            pulse(i == 2 ? 4'h2 : 4'h1);
            chk(divMode, i ? 2'h2 : 2'h3);
        end
        xfer(1'h1, 10'h0C4, 8'h90);
        xfer(1'h1, 10'h0C4, 8'h18);
        xfer(1'h0, 10'h0C4, 8'h00);
        chk(d, 32'h90);
        repeat (40) @(posedge clk);
        xfer(1'h1, 10'h0C4, 8'h10);
        xfer(1'h1, 10'h0C4, 8'h00);
        xfer(1'h0, 10'h0C4, 8'h00);
        chk(d, 32'h11);
        xfer(1'h1, 10'h091, 8'h02);
        pulse(4'h8);
        xfer(1'h0, 10'h0C4, 8'h00);
        chk(d, 32'h80);
        xfer(1'h1, 10'h087, 8'h02);
        repeat (2) @(posedge clk);
        chk(stopMode, 1'h1);
        pulse(4'h2);
        chk({stopMode, ringClock}, 2'h1);
        repeat (70) @(posedge clk);
        chk(ringClock, 1'h0);
        xfer(1'h1, 10'h0D8, 8'h20);
        pulse(4'h4);
        xfer(1'h0, 10'h0D8, 8'h00);
        chk(d[6:4], 3'h3);
        chk(pfIrq, 1'h1);
        xfer(1'h1, 10'h0E8, 8'h10);
        xfer(1'h1, 10'h0D8, 8'h03);
        repeat (900) @(posedge clk);
        xfer(1'h1, 10'h0D8, 8'h03);
        repeat (300) @(posedge clk);
        xfer(1'h0, 10'h0D8, 8'h00);
        chk(d, 32'h02);
        repeat (800) @(posedge clk);
        chk(wdIrq, 1'h1);
        i = 0;
        repeat (600) @(posedge clk) i += wdRst;
        chk(i, 32'h1);
        xfer(1'h0, 10'h0D8, 8'h00);
        chk({d[7:0], wdIrq}, 9'h008);
        xfer(1'h1, 10'h087, 8'h01);
        xfer(1'h0, 10'h087, 8'h00);
        chk(d, 32'h01);
        // power-on reset in mid-run, then stop with ring select clear
        arst_n <= 1'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        xfer(1'h1, 10'h087, 8'h03);
        pulse(4'h4);
        chk({stopMode, refAct}, 2'h2);
        xfer(1'h0, 10'h0D8, 8'h00);
        chk(d, 32'h40);
        xfer(1'h0, 10'h091, 8'h00);
        chk(d, 32'h00);
        pulse(4'h2);
        chk({stopMode, hold}, 2'h1);
        repeat (70) @(posedge clk);
        chk(hold, 1'h0);
        xfer(1'h0, 10'h087, 8'h00);
        chk(d, 32'h00);
        report_and_stop(1'h0);
    end
endmodule // tb_power_clock_management
